// ---- common/jtm_pkg.sv ----
// shared constants of the tap-master host port
`default_nettype none
package jtm_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam logic [2:0] ADDR_CONFIG_A = 3'h0;
	localparam logic [2:0] ADDR_CONFIG_B = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h2;
	localparam logic [2:0] ADDR_COMMAND = 3'h3;
	localparam logic [2:0] ADDR_SCAN_OUT = 3'h4;
	localparam logic [2:0] ADDR_SCAN_IN = 3'h5;
	localparam logic [2:0] ADDR_COUNTER = 3'h6;
	localparam logic [2:0] ADDR_PIN_CTRL = 3'h7;
	// ************************************************
	// reset values and writable masks
	// ************************************************
	localparam logic [7:0] RST_CONFIG_A = 8'h00;
	localparam logic [7:0] RST_CONFIG_B = 8'h80;
	localparam logic [7:0] RST_COMMAND = 8'h00;
	localparam logic [7:0] RST_SCAN_OUT = 8'h00;
	localparam logic [7:0] RST_SCAN_IN = 8'h00;
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [7:0] RST_PIN_CTRL = 8'h00;
	localparam logic [7:0] MASK_CONFIG_A = 8'h3f;
	localparam logic [7:0] MASK_PIN_CTRL = 8'h0f;
	localparam logic [7:0] MASK_ALL = 8'hff;
	// ************************************************
	// field positions
	// ************************************************
	localparam int unsigned CMD_SOFT_RESET_BIT = 7;
	localparam int unsigned CMD_OPCODE_LSB = 0;
	localparam int unsigned CMD_OPCODE_W = 4;
	localparam int unsigned CFGB_RETIME_LSB = 0;
	localparam int unsigned CFGB_RETIME_W = 4;
	localparam int unsigned STAT_IN_EMPTY_BIT = 7;
	localparam int unsigned STAT_OUT_FULL_BIT = 6;
	localparam int unsigned STAT_CTR_STATE_BIT = 5;
	localparam int unsigned STAT_TAP_W = 2;
	// ************************************************
	// timing and depths
	// ************************************************
	localparam int unsigned OUT_FIFO_DEPTH = 16;
	localparam logic [3:0] LEAD_MAX = 4'h4;
	localparam int unsigned READY_SAMPLE_CYCLES = 4;
	localparam int unsigned STROBE_GAP_CYCLES = 3;
	localparam int unsigned HOST_TIMEOUT_CYCLES = 1024;
endpackage
`default_nettype wire

// ---- common/jtm_host_if.sv ----
// host bus between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface jtm_host_if;
	logic       host_strobe_n;
	logic       rw_sel;
	logic [2:0] addr;
	logic [7:0] host_data;
	logic       host_data_oe;
	logic [7:0] dev_data;
	logic       dev_data_oe;
	logic       ready;
	logic [7:0] data_bus;

	// resolved shared data wire; an undriven bus reads as zero
	assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);

	modport dev (
		input  host_strobe_n, rw_sel, addr, data_bus,
		output dev_data, dev_data_oe, ready
	);
	modport host (
		input  data_bus, ready,
		output host_strobe_n, rw_sel, addr, host_data, host_data_oe
	);
endinterface
`default_nettype wire

// ---- rtl/jtm_device.sv ----
// device end of the host port: fifo, register file and ready logic
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// scan-out fifo
// ************************************************
module jtm_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             rst_b_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW+1:0]    fill;
	logic             push;
	logic             load;

	// the output register holds a word too, so it counts towards the depth
	assign fill = (PW+2)'(count) + (PW+2)'(out_valid_out);
	assign in_ready_out = fill < (PW+2)'(DEPTH);
	assign push = in_valid_in && in_ready_out;
	// registered output stage keeps the drain data straight from flops
	assign load = (count != '0) && (!out_valid_out || out_ready_in);

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (load) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !load) begin
				count <= count + 1'b1;
			end else if (load && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (load) begin
			out_valid_out <= 1'b1;
			out_data_out <= mem[rd_ptr];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule

// ************************************************
// device end
// ************************************************
module jtm_device (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_b_in,
	// host bus
	jtm_host_if.dev         bus,
	// configuration and command towards the scan engine
	output logic [7:0]      config_a_out,
	output logic [7:0]      config_b_out,
	output logic [7:0]      command_out,
	output logic [7:0]      counter_out,
	output logic [7:0]      pin_control_out,
	output logic            soft_reset_out,
	// engine state
	input  wire logic       command_done_in,
	input  wire logic       out_buf_resetting_in,
	input  wire logic       full_duplex_in,
	input  wire logic       counter_state_in,
	input  wire logic [1:0] tap_state_in,
	// scan-out stream to the engine
	output logic            scan_out_valid_out,
	output logic [7:0]      scan_out_data_out,
	input  wire logic       scan_out_ready_in,
	// scan-in stream from the engine
	input  wire logic       scan_in_valid_in,
	input  wire logic [7:0] scan_in_data_in,
	output logic            scan_in_ready_out
);
	logic       host_strobe_n_s1;
	logic       host_strobe_n_s2;
	logic       host_strobe_n_s3;
	logic [7:0] data_d1;
	logic [7:0] data_d2;
	logic       in_access;
	logic       granted;
	logic       rw_q;
	logic [2:0] addr_q;
	logic       host_strobe_n_fall;
	logic       host_strobe_n_rise;
	logic       busy;
	logic       blocked;
	logic       grant_now;
	logic       commit;
	logic       next_in_access;
	logic       next_granted;
	logic       next_rw;
	logic       fifo_in_ready;
	logic       out_full_flag;
	logic       in_full;
	logic [7:0] in_buf;
	logic [7:0] last_out;
	logic [3:0] lead;
	logic       lead_on;
	logic       push_out;
	logic       pop_in;
	logic [7:0] rd_value;

	// ************************************************
	// strobe synchroniser
	// ************************************************
	// first stage feeds only the second; edges come from stages two and three
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			host_strobe_n_s1 <= 1'b1;
			host_strobe_n_s2 <= 1'b1;
			host_strobe_n_s3 <= 1'b1;
			data_d1 <= 8'h00;
			data_d2 <= 8'h00;
		end else begin
			host_strobe_n_s1 <= bus.host_strobe_n;
			host_strobe_n_s2 <= host_strobe_n_s1;
			host_strobe_n_s3 <= host_strobe_n_s2;
			data_d1 <= bus.data_bus;
			data_d2 <= data_d1;
		end
	end

	assign host_strobe_n_fall = host_strobe_n_s3 && !host_strobe_n_s2;
	assign host_strobe_n_rise = !host_strobe_n_s3 && host_strobe_n_s2;

	// ************************************************
	// blocking conditions
	// ************************************************
	assign busy = command_out[jtm_pkg::CMD_OPCODE_LSB +: jtm_pkg::CMD_OPCODE_W] != '0;
	assign out_full_flag = !fifo_in_ready || out_buf_resetting_in;
	assign lead_on = full_duplex_in
		&& (config_b_out[jtm_pkg::CFGB_RETIME_LSB +: jtm_pkg::CFGB_RETIME_W] != '0);

	always_comb begin
		blocked = 1'b0;
		if (rw_q) begin
			blocked = (addr_q == jtm_pkg::ADDR_SCAN_IN) && !in_full;
		end else begin
			case (addr_q)
				jtm_pkg::ADDR_SCAN_OUT: begin
					blocked = out_full_flag || (lead_on && lead >= jtm_pkg::LEAD_MAX);
				end
				jtm_pkg::ADDR_COMMAND: begin
					blocked = busy && !data_d2[jtm_pkg::CMD_SOFT_RESET_BIT];
				end
				jtm_pkg::ADDR_CONFIG_A, jtm_pkg::ADDR_CONFIG_B, jtm_pkg::ADDR_COUNTER: begin
					blocked = busy;
				end
				default: begin
					blocked = 1'b0;
				end
			endcase
		end
	end

	// ************************************************
	// access sequencing
	// ************************************************
	assign grant_now = in_access && !granted && !blocked && !host_strobe_n_rise;
	assign commit = host_strobe_n_rise && in_access && granted && !rw_q;
	assign next_in_access = host_strobe_n_fall ? 1'b1 : (host_strobe_n_rise ? 1'b0 : in_access);
	assign next_granted = host_strobe_n_fall ? 1'b0 : (host_strobe_n_rise ? 1'b0 : (granted || grant_now));
	assign next_rw = host_strobe_n_fall ? bus.rw_sel : rw_q;
	assign push_out = commit && (addr_q == jtm_pkg::ADDR_SCAN_OUT);
	assign pop_in = grant_now && rw_q && (addr_q == jtm_pkg::ADDR_SCAN_IN);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			in_access <= 1'b0;
			granted <= 1'b0;
			rw_q <= 1'b1;
			addr_q <= 3'h0;
		end else begin
			in_access <= next_in_access;
			granted <= next_granted;
			rw_q <= next_rw;
			if (host_strobe_n_fall) begin
				addr_q <= bus.addr;
			end
		end
	end

	// ready drops at every access start and stays low until the access is granted or the strobe rises, one cycle if nothing blocks it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus.ready <= 1'b1;
			bus.dev_data_oe <= 1'b0;
		end else begin
			bus.ready <= !next_in_access || next_granted;
			bus.dev_data_oe <= next_in_access && next_rw;
		end
	end

	always_comb begin
		case (addr_q)
			jtm_pkg::ADDR_CONFIG_A: rd_value = config_a_out;
			jtm_pkg::ADDR_CONFIG_B: rd_value = config_b_out;
			jtm_pkg::ADDR_STATUS: rd_value = {!in_full, out_full_flag, counter_state_in,
				3'h0, tap_state_in};
			jtm_pkg::ADDR_COMMAND: rd_value = command_out;
			jtm_pkg::ADDR_SCAN_OUT: rd_value = last_out;
			jtm_pkg::ADDR_SCAN_IN: rd_value = in_buf;
			jtm_pkg::ADDR_COUNTER: rd_value = counter_out;
			default: rd_value = pin_control_out;
		endcase
	end

	// bus content is don't-care until the grant loads it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus.dev_data <= 8'h00;
		end else if (grant_now && rw_q) begin
			bus.dev_data <= rd_value;
		end
	end

	// ************************************************
	// register file
	// ************************************************
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			config_a_out <= jtm_pkg::RST_CONFIG_A;
			config_b_out <= jtm_pkg::RST_CONFIG_B;
			command_out <= jtm_pkg::RST_COMMAND;
			counter_out <= jtm_pkg::RST_COUNTER;
			pin_control_out <= jtm_pkg::RST_PIN_CTRL;
			last_out <= jtm_pkg::RST_SCAN_OUT;
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= 1'b0;
			if (command_done_in) begin
				command_out[jtm_pkg::CMD_OPCODE_LSB +: jtm_pkg::CMD_OPCODE_W] <= '0;
			end
			if (commit) begin
				case (addr_q)
					jtm_pkg::ADDR_CONFIG_A: config_a_out <= data_d2 & jtm_pkg::MASK_CONFIG_A;
					jtm_pkg::ADDR_CONFIG_B: config_b_out <= data_d2 & jtm_pkg::MASK_ALL;
					jtm_pkg::ADDR_COUNTER: counter_out <= data_d2;
					jtm_pkg::ADDR_SCAN_OUT: last_out <= data_d2;
					jtm_pkg::ADDR_PIN_CTRL: begin
						if (!busy) begin
							pin_control_out <= data_d2 & jtm_pkg::MASK_PIN_CTRL;
						end
					end
					jtm_pkg::ADDR_COMMAND: begin
						if (data_d2[jtm_pkg::CMD_SOFT_RESET_BIT]) begin
							soft_reset_out <= 1'b1;
							command_out <= {1'b0, data_d2[6:4], 4'h0};
						end else begin
							command_out <= data_d2;
						end
					end
					default: begin
						// status and scan-in take no writes
					end
				endcase
			end
		end
	end

	// ************************************************
	// scan-in holding byte and lead counter
	// ************************************************
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			in_full <= 1'b0;
			in_buf <= jtm_pkg::RST_SCAN_IN;
			scan_in_ready_out <= 1'b1;
		end else begin
			// push only when empty, pop only when full, so the two never meet
			if (scan_in_valid_in && scan_in_ready_out) begin
				in_full <= 1'b1;
				in_buf <= scan_in_data_in;
				scan_in_ready_out <= 1'b0;
			end else if (pop_in) begin
				in_full <= 1'b0;
				scan_in_ready_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lead <= 4'h0;
		end else if (!lead_on) begin
			lead <= 4'h0;
		end else if (push_out && !pop_in) begin
			lead <= lead + 4'h1;
		end else if (pop_in && !push_out && lead != 4'h0) begin
			lead <= lead - 4'h1;
		end
	end

	jtm_fifo #(
		.WIDTH (8),
		.DEPTH (jtm_pkg::OUT_FIFO_DEPTH)
	) u_out_fifo (
		.ref_clk_in    (ref_clk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (push_out),
		.in_data_in    (data_d2),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (scan_out_valid_out),
		.out_data_out  (scan_out_data_out),
		.out_ready_in  (scan_out_ready_in)
	);
endmodule
`default_nettype wire

// ---- rtl/jtm_host.sv ----
// host end of the host port: one strobed access per request
`timescale 1ns/1ps
`default_nettype none
module jtm_host #(
	parameter int unsigned TIMEOUT_CYCLES = jtm_pkg::HOST_TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_b_in,
	// host bus
	jtm_host_if.host        bus,
	// request side
	input  wire logic       req_valid_in,
	input  wire logic       req_write_in,
	input  wire logic [2:0] req_addr_in,
	input  wire logic [7:0] req_data_in,
	output logic            req_ready_out,
	// completion side
	output logic            done_valid_out,
	output logic [7:0]      done_data_out,
	output logic            done_aborted_out
);
	typedef enum logic [2:0] {
		JTM_IDLE,
		JTM_LOW,
		JTM_RELEASE,
		JTM_GAP
	} jtm_state_e;

	jtm_state_e state;
	logic [15:0] timer;
	logic        aborted;
	logic [7:0]  wmask;

	// reserved bits forced to zero on the way out
	always_comb begin
		case (req_addr_in)
			jtm_pkg::ADDR_CONFIG_A: wmask = jtm_pkg::MASK_CONFIG_A;
			jtm_pkg::ADDR_PIN_CTRL: wmask = jtm_pkg::MASK_PIN_CTRL;
			default: wmask = jtm_pkg::MASK_ALL;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= JTM_IDLE;
			timer <= 16'h0000;
			aborted <= 1'b0;
			req_ready_out <= 1'b1;
			done_valid_out <= 1'b0;
			done_data_out <= 8'h00;
			done_aborted_out <= 1'b0;
			bus.host_strobe_n <= 1'b1;
			bus.rw_sel <= 1'b1;
			bus.addr <= 3'h0;
			bus.host_data <= 8'h00;
			bus.host_data_oe <= 1'b0;
		end else begin
			done_valid_out <= 1'b0;
			case (state)
				JTM_IDLE: begin
					if (req_valid_in && req_ready_out) begin
						req_ready_out <= 1'b0;
						bus.rw_sel <= !req_write_in;
						bus.addr <= req_addr_in;
						bus.host_data <= req_data_in & wmask;
						bus.host_data_oe <= req_write_in;
						bus.host_strobe_n <= 1'b0;
						timer <= 16'h0000;
						state <= JTM_LOW;
					end
				end
				JTM_LOW: begin
					timer <= timer + 16'h0001;
					// ready is only trusted once the device has seen the strobe
					if (timer >= 16'(jtm_pkg::READY_SAMPLE_CYCLES - 1) && bus.ready) begin
						done_data_out <= bus.data_bus;
						aborted <= 1'b0;
						bus.host_strobe_n <= 1'b1;
						state <= JTM_RELEASE;
					end else if (timer >= 16'(TIMEOUT_CYCLES - 1)) begin
						aborted <= 1'b1;
						bus.host_strobe_n <= 1'b1;
						state <= JTM_RELEASE;
					end
				end
				JTM_RELEASE: begin
					// data held one cycle past the strobe edge for the device's sampling
					bus.host_data_oe <= 1'b0;
					timer <= 16'h0000;
					done_valid_out <= 1'b1;
					done_aborted_out <= aborted;
					state <= JTM_GAP;
				end
				JTM_GAP: begin
					timer <= timer + 16'h0001;
					if (timer >= 16'(jtm_pkg::STROBE_GAP_CYCLES - 1)) begin
						req_ready_out <= 1'b1;
						state <= JTM_IDLE;
					end
				end
				default: begin
					state <= JTM_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb/jtm_port_sva.sv ----
// bus checker for the tap-master host port
`timescale 1ns/1ps
`default_nettype none
module jtm_port_sva #(
	parameter int unsigned TIMEOUT_CYCLES = 16
) (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_b_in,
	// host bus
	input  wire logic       host_strobe_n,
	input  wire logic       rw_sel,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] host_data,
	input  wire logic       host_data_oe,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_data_oe,
	input  wire logic       ready,
	input  wire logic [7:0] data_bus
);
	// ************************************************
	// strobe-low length, bounds any stall
	// ************************************************
	int unsigned low_cnt;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt <= 0;
		end else if (host_strobe_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	// ************************************************
	// properties
	// ************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	AST_WRITE_NO_DRIVE: assert property ((!host_strobe_n && !rw_sel) |-> (!dev_data_oe && host_data_oe))
		else $error("device drives bus during write");
	AST_NO_CONTENTION: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the bus");
	AST_WRITE_DATA_HELD: assert property (($rose(host_strobe_n) && !rw_sel) |-> (host_data_oe && $stable(host_data)))
		else $error("write data not held at strobe rise");
	AST_STALL_DIP: assert property ($fell(host_strobe_n) |-> ##[1:4] !ready)
		else $error("ready did not drop for access");
	AST_IDLE_READY: assert property (host_strobe_n [*6] |-> ready)
		else $error("ready low while idle");
	AST_GRANT_DATA: assert property (($rose(ready) && !host_strobe_n && rw_sel) |-> (dev_data_oe && data_bus == dev_data) ##1 ready)
		else $error("read grant without driven data");
	AST_READ_DRIVE: assert property (($fell(host_strobe_n) && rw_sel) |-> ##[1:4] dev_data_oe)
		else $error("read data not driven");
	AST_IDLE_RELEASE: assert property (host_strobe_n [*5] |-> !dev_data_oe)
		else $error("bus driven with strobe high");
	AST_ADDR_STABLE: assert property ((!host_strobe_n && !$past(host_strobe_n)) |-> ($stable(addr) && $stable(rw_sel)))
		else $error("address or direction moved during strobe");
	AST_ABORT_BOUND: assert property (low_cnt <= TIMEOUT_CYCLES + 8)
		else $error("stalled access not aborted");
endmodule
`default_nettype wire

// ---- tb/test_jtag_master_host_port.sv ----
// self-checking bench: host end and device end joined by the host bus
`timescale 1ns/1ps
`default_nettype none
module test_jtag_master_host_port;
	// ************************************************
	// stimulus and observation
	// ************************************************
	logic ref_clk_in, rst_b_in, req_valid, req_write, req_ready_out, done_valid_out, ab;
	logic cmd_done, buf_resetting, full_duplex, out_ready, in_valid, soft_reset_out, sr_seen;
	logic scan_out_valid_out, scan_in_ready_out, done_aborted_out;
	logic [2:0] req_addr;
	logic [7:0] req_data, in_data, q, done_data_out, config_a_out, command_out, scan_out_data_out;
	logic [7:0] config_b_out, counter_out, pin_control_out;
	logic [7:0] popped[$];
	int err_count, n_compared;

	jtm_host_if jtm_host_if_inst ();
	jtm_device jtm_device_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.bus(jtm_host_if_inst), .config_a_out(config_a_out), .config_b_out(config_b_out),
		.command_out(command_out), .counter_out(counter_out),
		.pin_control_out(pin_control_out),
		.soft_reset_out(soft_reset_out), .command_done_in(cmd_done),
		.out_buf_resetting_in(buf_resetting), .full_duplex_in(full_duplex),
		.counter_state_in(1'b1), .tap_state_in(2'h2),
		.scan_out_valid_out(scan_out_valid_out), .scan_out_data_out(scan_out_data_out),
		.scan_out_ready_in(out_ready), .scan_in_valid_in(in_valid),
		.scan_in_data_in(in_data), .scan_in_ready_out(scan_in_ready_out));
	// short timeout keeps aborted stalls cheap
	jtm_host #(.TIMEOUT_CYCLES(64)) jtm_host_inst (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .bus(jtm_host_if_inst), .req_valid_in(req_valid),
		.req_write_in(req_write), .req_addr_in(req_addr), .req_data_in(req_data),
		.req_ready_out(req_ready_out), .done_valid_out(done_valid_out),
		.done_data_out(done_data_out), .done_aborted_out(done_aborted_out));
	jtm_port_sva #(.TIMEOUT_CYCLES(64)) jtm_port_sva_inst (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .host_strobe_n(jtm_host_if_inst.host_strobe_n),
		.rw_sel(jtm_host_if_inst.rw_sel), .addr(jtm_host_if_inst.addr),
		.host_data(jtm_host_if_inst.host_data), .host_data_oe(jtm_host_if_inst.host_data_oe),
		.dev_data(jtm_host_if_inst.dev_data), .dev_data_oe(jtm_host_if_inst.dev_data_oe),
		.ready(jtm_host_if_inst.ready), .data_bus(jtm_host_if_inst.data_bus));

	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		if (scan_out_valid_out === 1'b1 && out_ready === 1'b1) popped.push_back(scan_out_data_out);
		if (soft_reset_out === 1'b1) sr_seen = 1'b1;
	end
	// ************************************************
	// helpers
	// ************************************************
	task report_and_stop;
		if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready_out !== 1'b1 && n < 200) begin tick(1); n++; end
		req_valid = 1'b1; req_write = w; req_addr = a; req_data = d;
		tick(1);
		req_valid = 1'b0;
		n = 0;
		while (done_valid_out !== 1'b1 && n < 200) begin tick(1); n++; end
		q = done_data_out;
		ab = done_aborted_out;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d, input logic x);
		acc(1'b1, a, d);
		chk({7'h00, ab}, {7'h00, x});
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e, input logic x);
		acc(1'b0, a, 8'h00);
		chk({7'h00, ab}, {7'h00, x});
		if (!x) chk(q, e);
	endtask
	task push_in(input logic [7:0] d);
		in_data = d; in_valid = 1'b1;
		tick(1);
		in_valid = 1'b0;
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task s_regs;
		rd(3'h0, 8'h00, 0); rd(3'h1, 8'h80, 0); rd(3'h3, 8'h00, 0);
		rd(3'h4, 8'h00, 0); rd(3'h6, 8'h00, 0); rd(3'h7, 8'h00, 0);
		wr(3'h0, 8'hff, 0); rd(3'h0, 8'h3f, 0);
		wr(3'h7, 8'hff, 0); rd(3'h7, 8'h0f, 0);
		wr(3'h1, 8'h5a, 0); rd(3'h1, 8'h5a, 0);
		wr(3'h6, 8'ha5, 0); rd(3'h6, 8'ha5, 0);
		wr(3'h2, 8'h00, 0); rd(3'h2, 8'ha2, 0);
		chk(config_a_out, 8'h3f);
		chk(config_b_out, 8'h5a);
		chk(counter_out, 8'ha5);
		chk(pin_control_out, 8'h0f);
	endtask
	task s_scan_in;
		fork
			rd(3'h5, 8'h3c, 0);
			begin
				tick(20);
				chk({7'h00, req_ready_out}, 8'h00);
				push_in(8'h3c);
			end
		join
		rd(3'h5, 8'h00, 1);
		push_in(8'h77);
		chk({7'h00, scan_in_ready_out}, 8'h00);
		rd(3'h5, 8'h77, 0);
	endtask
	task s_busy;
		wr(3'h3, 8'h05, 0); rd(3'h3, 8'h05, 0);
		chk(command_out, 8'h05);
		fork
			wr(3'h0, 8'h11, 0);
			begin
				tick(20);
				chk({7'h00, req_ready_out}, 8'h00);
				cmd_done = 1'b1; tick(1); cmd_done = 1'b0;
			end
		join
		rd(3'h0, 8'h11, 0);
		wr(3'h3, 8'h06, 0); wr(3'h7, 8'h03, 0); rd(3'h7, 8'h0f, 0);
		sr_seen = 1'b0;
		wr(3'h3, 8'h80, 0);
		tick(4);
		chk({7'h00, sr_seen}, 8'h01);
		rd(3'h3, 8'h00, 0);
	endtask
	task s_fifo;
		for (int i = 0; i < 16; i++) wr(3'h4, 8'(i), 0);
		wr(3'h4, 8'hee, 1); rd(3'h2, 8'he2, 0); rd(3'h4, 8'h0f, 0);
		out_ready = 1'b1;
		tick(40);
		chk(8'(popped.size()), 8'h10);
		for (int i = 0; i < 16; i++) chk(popped.pop_front(), 8'(i));
		buf_resetting = 1'b1;
		fork
			wr(3'h4, 8'he1, 0);
			begin
				tick(20);
				chk({7'h00, req_ready_out}, 8'h00);
				buf_resetting = 1'b0;
			end
		join
		tick(10);
		chk(popped.pop_front(), 8'he1);
	endtask
	task s_lead;
		full_duplex = 1'b1;
		for (int i = 0; i < 4; i++) wr(3'h4, 8'(i), 0);
		wr(3'h4, 8'h55, 1);
		push_in(8'h99);
		rd(3'h5, 8'h99, 0); wr(3'h4, 8'h55, 0);
		full_duplex = 1'b0;
	endtask
	// ************************************************
	// main sequence and watchdog
	// ************************************************
	initial begin
		rst_b_in = 1'b0; req_valid = 1'b0; req_write = 1'b0; req_addr = 3'h0;
		req_data = 8'h00; cmd_done = 1'b0; buf_resetting = 1'b0; full_duplex = 1'b0;
		out_ready = 1'b0; in_valid = 1'b0; in_data = 8'h00; sr_seen = 1'b0;
		err_count = 0; n_compared = 0;
		tick(2);
		rst_b_in = 1'b1;
		s_regs();
		s_scan_in();
		s_busy();
		s_fifo();
		s_lead();
		report_and_stop();
	end
	initial begin
		tick(20000);
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
